// [serial_led_onoff_shift_latch.sv]
// Overview of operation
// - The shift register and the on/off latch are each sixteen bits, one per output.
// - Each rising shift-clock edge moves the register one place up and loads serial_in at bit 0.
// - The serial output changes on the rising shift-clock edge and shows the bit leaving bit 15.
// - While latch_control is high the latch is transparent and follows the shift register.
// - While latch_control is low the latch holds whatever shifting happens.
// - Output n is steered by latch bit n, so output 0 carries the newest shifted bit.
// - With blanking low an output sinks current for a latch bit of 1 and is off for 0.
// - With blanking high every output is forced off whatever the latch holds.
// - The shift register and latch hold no defined value after power-up.
// - Outputs switch in four groups {0,7,8,15},{1,6,9,14},{2,5,10,13},{3,4,11,12}, 20 ns apart.
// - The serial output is taken straight from the register's top bit.
`default_nettype none

module serial_led_onoff_shift_latch
    import led_sink_pkg::*;
#(
    parameter int WIDTH = led_sink_pkg::CHANNELS,
    parameter int DEPTH = led_sink_pkg::FIFO_DEPTH,
    parameter int GROUP_CYCLES = led_sink_pkg::GROUP_DELAY_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_shift_clk,
    input wire logic i_serial_in,
    input wire logic i_latch_control,
    input wire logic i_blank,
    output logic o_serial_out,
    output logic [led_sink_pkg::CHANNELS-1:0] o_sink_output_n,
    output logic o_shift_ready,
    output logic o_seq_busy
);
    import led_sink_pkg::*;

    // The channel width is fixed by the group masks; the wait counter needs two cycles.
    if (WIDTH != CHANNELS) begin : g_bad_width
        $error("serial_led_onoff_shift_latch supports exactly 16 channels");
    end
    if (GROUP_CYCLES < 2 || GROUP_CYCLES > 255) begin : g_bad_delay
        $error("serial_led_onoff_shift_latch group delay must be 2 to 255 cycles");
    end
    if (DEPTH < 4) begin : g_bad_depth
        $error("serial_led_onoff_shift_latch buffer depth must be at least 4");
    end

    localparam logic [7:0] WAIT_LOAD = 8'(GROUP_CYCLES - 2);

    // ------------------------------------------------------------------
    // Link domain: the shift register runs on the controller's clock.
    // ------------------------------------------------------------------
    logic [15:0] shift_q;
    wire logic [15:0] shift_d = {shift_q[14:0], i_serial_in};
    shift_word_s wr_word;
    logic wr_ready;

    // Only rising edges move data; the register has no reset value.
    always_ff @(posedge i_shift_clk) begin
        shift_q <= shift_d;
    end

    // The top bit drives the cascade output directly.
    assign o_serial_out = shift_q[15];

    // Each shift event is posted with the latch level seen at that edge.
    assign wr_word.latch_open = i_latch_control;
    assign wr_word.bits = shift_d;
    assign o_shift_ready = wr_ready;

    // ------------------------------------------------------------------
    // Crossing: shift events travel to the system clock through a buffer.
    // ------------------------------------------------------------------
    shift_word_s rd_word;
    logic rd_valid;
    logic rd_ready;

    async_word_fifo #(
        .WIDTH($bits(shift_word_s)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_wr_clk(i_shift_clk),
        .i_rd_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_wr_valid(1'b1),
        .o_wr_ready(wr_ready),
        .i_wr_data(wr_word),
        .o_rd_valid(rd_valid),
        .i_rd_ready(rd_ready),
        .o_rd_data(rd_word)
    );

    // Latch and blanking pins are levels from outside; two flops each.
    logic [1:0] pins_sync;

    sync_2ff #(.W(2)) u_pin_sync (
        .i_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_d({i_blank, i_latch_control}),
        .o_q(pins_sync)
    );

    wire logic lat_open = pins_sync[0];
    wire logic blank = pins_sync[1];

    // ------------------------------------------------------------------
    // System domain: shift mirror and the on/off latch.
    // ------------------------------------------------------------------
    logic [15:0] mirror_q;
    logic [15:0] latch_q;
    seq_state_e state_q;
    seq_state_e state_d;
    wire logic pop = rd_valid && rd_ready;
    wire logic pop_open = pop && (rd_word.latch_open || lat_open);

    // Latch takes a shift event that happened while open, or copies the mirror while open.
    wire logic [15:0] latch_d = pop_open ? rd_word.bits :
                                lat_open ? mirror_q : latch_q;
    wire logic [15:0] mirror_d = pop ? rd_word.bits : mirror_q;

    // Mirror and latch carry data only and are left undefined at power-up.
    always_ff @(posedge i_sys_clk) begin
        mirror_q <= mirror_d;
        latch_q <= latch_d;
    end

    // ------------------------------------------------------------------
    // Group sequencer: output changes are staged group by group.
    // ------------------------------------------------------------------
    logic [15:0] target_q;
    logic [15:0] sink_q;
    logic [1:0] grp_q;
    logic [7:0] wait_q;

    // Blanking wins over the latch; latch bit n steers output n.
    wire logic [15:0] target_now = blank ? '0 : latch_q;
    wire logic [15:0] cur_mask = group_mask(grp_q);
    wire logic start = (state_q == SEQ_IDLE) && (target_now != sink_q);
    wire logic last_grp = grp_q == LAST_GROUP;
    wire logic [15:0] sink_d = (sink_q & ~cur_mask) | (target_q & cur_mask);

    // The buffer is drained only while no group sequence runs.
    assign rd_ready = state_q == SEQ_IDLE;
    assign o_seq_busy = state_q != SEQ_IDLE;

    // Next state of the sequencer.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SEQ_IDLE: begin
                if (start) begin
                    state_d = SEQ_APPLY;
                end
            end
            SEQ_APPLY: begin
                state_d = last_grp ? SEQ_IDLE : SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (wait_q == 8'h00) begin
                    state_d = SEQ_APPLY;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= SEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Target snapshot, taken once so that all groups see the same pattern.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            target_q <= SINK_RESET;
        end else if (start) begin
            target_q <= target_now;
        end
    end

    // Group index and the gap between groups.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            grp_q <= GROUP_RESET;
            wait_q <= 8'h00;
        end else if (state_q == SEQ_APPLY) begin
            grp_q <= last_grp ? GROUP_RESET : grp_q + 2'h1;
            wait_q <= WAIT_LOAD;
        end else if (state_q == SEQ_WAIT) begin
            wait_q <= wait_q - 8'h01;
        end
    end

    // Output flops switch one group per apply step, on and off alike.
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sink_q <= SINK_RESET;
        end else if (state_q == SEQ_APPLY) begin
            sink_q <= sink_d;
        end
    end

    assign o_sink_output_n = sink_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb_sys @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    // One apply step of a given group.
    sequence s_apply(logic [1:0] g);
        state_q == SEQ_APPLY && grp_q == g;
    endsequence

    // Rest of a pass after group 0: groups 1 to 3, four cycles apart.
    sequence s_group_walk;
        ##4 s_apply(2'h1) ##4 s_apply(2'h2) ##4 s_apply(2'h3);
    endsequence

    a_shift_lsb_load: assert property (
        @(posedge i_shift_clk) disable iff (!i_nrst)
        1'b1 |=> shift_q[0] == $past(i_serial_in))
        else $error("shift register bit 0 did not take serial input");

    a_shift_msb_move: assert property (
        @(posedge i_shift_clk) disable iff (!i_nrst)
        1'b1 |=> shift_q[15:1] === $past(shift_q[14:0]))
        else $error("shift register did not move toward the top bit");

    a_serial_out_msb: assert property (
        @(posedge i_shift_clk) disable iff (!i_nrst)
        1'b1 |=> o_serial_out === $past(shift_q[14]))
        else $error("serial output is not the bit shifted out of the top");

    a_latch_closed_holds: assert property (
        (!lat_open && !pop_open) |=> latch_q === $past(latch_q))
        else $error("latch changed while closed");

    a_latch_open_follows: assert property (
        (lat_open && !pop) |=> latch_q === $past(mirror_q))
        else $error("open latch did not follow the shift register");

    a_group_walk_order: assert property (
        s_apply(2'h0) |-> s_group_walk)
        else $error("groups did not switch in order four cycles apart");

    a_group_mask_only: assert property (
        (o_sink_output_n != $past(o_sink_output_n)) |->
        ((o_sink_output_n ^ $past(o_sink_output_n)) & ~group_mask($past(grp_q))) == '0)
        else $error("outputs outside the active group changed");

    a_walk_end_target: assert property (
        s_apply(2'h3) |=> o_sink_output_n == $past(target_q))
        else $error("outputs do not match the pattern after the last group");

    a_blank_forces_off: assert property (
        blank [*2] |-> ##[1:40] (o_sink_output_n == '0 || !blank))
        else $error("blanking did not turn all outputs off");

endmodule

`default_nettype wire

// [led_sink_pkg.sv]
`default_nettype none

package led_sink_pkg;

    // Channel count and buffering depth.
    localparam int CHANNELS = 16;
    localparam int FIFO_DEPTH = 8;

    // Timing of the grouped output switching.
    localparam int SYS_CLK_PERIOD_PS = 5000;
    localparam int GROUP_DELAY_NS = 20;
    localparam int GROUP_DELAY_CYCLES =
        (GROUP_DELAY_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    localparam int GROUP_COUNT = 4;

    // Output groups in switching order.
    localparam logic [15:0] GROUP0_MASK = 16'h8181;
    localparam logic [15:0] GROUP1_MASK = 16'h4242;
    localparam logic [15:0] GROUP2_MASK = 16'h2424;
    localparam logic [15:0] GROUP3_MASK = 16'h1818;

    // Reset values of the control state, and the index of the last group.
    localparam logic [15:0] SINK_RESET = 16'h0000;
    localparam logic [1:0] GROUP_RESET = 2'h0;
    localparam logic [1:0] LAST_GROUP = 2'h3;

    // One shift event as it crosses to the system clock.
    typedef struct packed {
        logic latch_open;
        logic [15:0] bits;
    } shift_word_s;

    // Group sequencer states, Gray coded along idle, apply, wait, apply.
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_APPLY = 2'b01,
        SEQ_WAIT = 2'b11
    } seq_state_e;

    // Channel mask of one switching group.
    function automatic logic [15:0] group_mask(input logic [1:0] grp);
        logic [15:0] m;
        m = GROUP0_MASK;
        unique case (grp)
            2'h0: m = GROUP0_MASK;
            2'h1: m = GROUP1_MASK;
            2'h2: m = GROUP2_MASK;
            2'h3: m = GROUP3_MASK;
        endcase
        return m;
    endfunction

endpackage

`default_nettype wire

// [sync_2ff.sv]
`default_nettype none

module sync_2ff #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two flops; only the second one drives the output.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

`default_nettype wire

// [async_word_fifo.sv]
`default_nettype none

module async_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic i_wr_clk,
    input wire logic i_rd_clk,
    input wire logic i_nrst,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    // Gray pointers need a power-of-two depth of at least four.
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("async_word_fifo depth must be a power of two, at least 4");
    end

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wbin_q;
    logic [AW:0] wgray_q;
    logic [AW:0] rbin_q;
    logic [AW:0] rgray_q;
    logic [AW:0] rgray_wr;
    logic [AW:0] wgray_rd;
    wire logic push = i_wr_valid && o_wr_ready;
    wire logic pop = o_rd_valid && i_rd_ready;
    wire logic [AW:0] wbin_d = wbin_q + (AW+1)'(1);
    wire logic [AW:0] rbin_d = rbin_q + (AW+1)'(1);

    // Pointers cross as Gray codes through two flops each way.
    sync_2ff #(.W(AW + 1)) u_rptr_sync (
        .i_clk(i_wr_clk),
        .i_nrst(i_nrst),
        .i_d(rgray_q),
        .o_q(rgray_wr)
    );
    sync_2ff #(.W(AW + 1)) u_wptr_sync (
        .i_clk(i_rd_clk),
        .i_nrst(i_nrst),
        .i_d(wgray_q),
        .o_q(wgray_rd)
    );

    // Full when the write pointer is one lap ahead of the read pointer.
    assign o_wr_ready = wgray_q != {~rgray_wr[AW:AW-1], rgray_wr[AW-2:0]};
    assign o_rd_valid = rgray_q != wgray_rd;
    assign o_rd_data = mem_q[rbin_q[AW-1:0]];

    // Write side, on the link clock.
    always_ff @(posedge i_wr_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wbin_q <= '0;
            wgray_q <= '0;
        end else if (push) begin
            wbin_q <= wbin_d;
            wgray_q <= to_gray(wbin_d);
        end
    end

    // Storage has no reset; a word is only read after it was written.
    always_ff @(posedge i_wr_clk) begin
        if (push) begin
            mem_q[wbin_q[AW-1:0]] <= i_wr_data;
        end
    end

    // Read side, on the system clock.
    always_ff @(posedge i_rd_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rbin_q <= '0;
            rgray_q <= '0;
        end else if (pop) begin
            rbin_q <= rbin_d;
            rgray_q <= to_gray(rbin_d);
        end
    end
endmodule

`default_nettype wire

// [led_host_model.sv]
`default_nettype none

module led_host_model (
    input wire logic i_sys_clk,
    input wire logic i_serial_out,
    output logic o_shift_clk,
    output logic o_serial_in,
    output logic o_latch_control,
    output logic o_blank
);
    timeunit 1ns;
    timeprecision 100ps;

    // The shift clock stands still low between frames, and blanking starts high.
    initial begin
        o_shift_clk = 1'b0;
        o_serial_in = 1'b0;
        o_latch_control = 1'b0;
        o_blank = 1'b1;
    end

    // Shifts one word oldest bit first, data changing while the clock is low.
    // It records the serial output after each rising and each falling edge.
    task automatic send_frame(input logic [15:0] w, output logic [15:0] cap,
                              output logic [15:0] cap_fall);
        cap = 16'h0000;
        cap_fall = 16'h0000;
        #3;
        o_serial_in = w[15];
        #80;
        for (int i = 15; i >= 0; i--) begin
            o_shift_clk = 1'b1;
            #20;
            cap = {cap[14:0], i_serial_out};
            #60;
            o_shift_clk = 1'b0;
            if (i > 0) begin
                o_serial_in = w[i-1];
            end
            #79;
            cap_fall = {cap_fall[14:0], i_serial_out};
            #1;
        end
        // A released data line is not left at its last level.
        o_serial_in = ~o_serial_in;
    endtask

    // Latch and blanking levels change on the falling system clock edge.
    task automatic set_latch(input logic v);
        @(negedge i_sys_clk);
        o_latch_control = v;
    endtask

    task automatic set_blank(input logic v);
        @(negedge i_sys_clk);
        o_blank = v;
    endtask
endmodule

`default_nettype wire

// [serial_led_onoff_shift_latch_tb.sv]
`default_nettype none

module serial_led_onoff_shift_latch_tb;
    import led_sink_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    wire shift_clk;
    wire serial_in;
    wire latch_control;
    wire blank;
    wire serial_out;
    wire [15:0] sink_out;
    wire shift_ready;
    wire seq_busy;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] cap;
    logic [15:0] cap_fall;
    // Channel 1 is written 0 in WORD_A and 1 in WORD_B.
    localparam logic [15:0] WORD_A = 16'ha5c1;
    localparam logic [15:0] WORD_B = 16'h5a3e;

    // System clock at 200 MHz.
    always #2.5 sys_clk = ~sys_clk;

    serial_led_onoff_shift_latch i_serial_led_onoff_shift_latch (
        .i_sys_clk(sys_clk),
        .i_nrst(nrst),
        .i_shift_clk(shift_clk),
        .i_serial_in(serial_in),
        .i_latch_control(latch_control),
        .i_blank(blank),
        .o_serial_out(serial_out),
        .o_sink_output_n(sink_out),
        .o_shift_ready(shift_ready),
        .o_seq_busy(seq_busy)
    );

    led_host_model i_led_host_model (
        .i_sys_clk(sys_clk),
        .i_serial_out(serial_out),
        .o_shift_clk(shift_clk),
        .o_serial_in(serial_in),
        .o_latch_control(latch_control),
        .o_blank(blank)
    );

    // Compares a word and counts the outcome.
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Compares a single flag and counts the outcome.
    task automatic check1(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    // Waits a bounded time for the outputs to settle, then compares them.
    task automatic wait_out(input logic [15:0] exp, input string msg);
        int n;
        n = 0;
        while ((sink_out !== exp || seq_busy !== 1'b0) && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check16(sink_out, exp, msg);
    endtask

    // Follows one switching sequence group by group, spaced by the group delay.
    task automatic check_groups(input logic [15:0] old, input logic [15:0] nw);
        logic [15:0] gm [4] = '{GROUP0_MASK, GROUP1_MASK, GROUP2_MASK, GROUP3_MASK};
        logic [15:0] m;
        int n;
        n = 0;
        m = 16'h0000;
        while (sink_out === old && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        for (int g = 0; g < 4; g++) begin
            if (g > 0) begin
                repeat (GROUP_DELAY_CYCLES) @(posedge sys_clk);
                #1;
            end
            m = m | gm[g];
            check16(sink_out, (old & ~m) | (nw & m), "grouped switching");
        end
        @(posedge sys_clk);
        #1;
        check1(seq_busy, 1'b0, "sequence end");
    endtask

    // Reset holds outputs off and the buffer open.
    task automatic s_reset;
        repeat (4) @(negedge sys_clk);
        check16(sink_out, 16'h0000, "outputs in reset");
        check1(seq_busy, 1'b0, "busy in reset");
        check1(shift_ready, 1'b1, "ready in reset");
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
    endtask

    // Transparent loading under blanking, then blanking lifted.
    task automatic s_blank_load;
        i_led_host_model.set_latch(1'b1);
        i_led_host_model.send_frame(WORD_A, cap, cap_fall);
        repeat (40) @(negedge sys_clk);
        check16(sink_out, 16'h0000, "blanked while loading");
        check16(16'($bits(sink_out)), 16'h0010, "channel count");
        i_led_host_model.set_blank(1'b0);
        wait_out(WORD_A, "transparent load");
    endtask

    // Shifting with the latch closed, then opening it to take the new word.
    task automatic s_hold_then_open;
        i_led_host_model.set_latch(1'b0);
        i_led_host_model.send_frame(WORD_B, cap, cap_fall);
        repeat (40) @(negedge sys_clk);
        check16(sink_out, WORD_A, "held while shifting");
        check16(cap, {WORD_A[14:0], WORD_B[15]}, "serial out chain");
        check16(cap_fall, cap, "falling edges inert");
        check1(shift_ready, 1'b1, "buffer not full");
        i_led_host_model.set_latch(1'b1);
        check_groups(WORD_A, WORD_B);
    endtask

    // Blanking forces every output off and releasing it restores the latch.
    task automatic s_blank_force;
        i_led_host_model.set_blank(1'b1);
        wait_out(16'h0000, "blank forces off");
        i_led_host_model.set_blank(1'b0);
        wait_out(WORD_B, "outputs restored");
        i_led_host_model.set_latch(1'b0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        s_reset();
        s_blank_load();
        s_hold_then_open();
        s_blank_force();
        give_verdict();
    end

    // Cuts a hang short well beyond the expected run time.
    initial begin
        #100us;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule

`default_nettype wire
